// file: core/mpr_defs.vh
// Constants for the memory port information and barrier register bank
`ifndef MPR_DEFS_VH
`define MPR_DEFS_VH

`define MPR_ADDR_W          8
`define MPR_OFF_BARRIER     8'hE8
`define MPR_OFF_CONFIG      8'hF4
`define MPR_OFF_BASE_HIGH   8'hF0
`define MPR_OFF_BASE_LOW    8'hF8
`define MPR_OFF_IDENT       8'hFC
`define MPR_OFF_TAR_HIGH    8'h08

`define MPR_BAR_TRIG_BIT    0
`define MPR_BAR_TYPE_LSB    1
`define MPR_BAR_TYPE_MSB    2
`define MPR_BAR_TYPE_RST    2'h0
`define MPR_BAR_TRIG_RST    1'h0
`define MPR_BAR_NORMAL      2'h0
`define MPR_BAR_MEMORY      2'h1
`define MPR_BAR_RESERVED    2'h2
`define MPR_BAR_SYNC        2'h3

`define MPR_CFG_BE_BIT      0
`define MPR_CFG_LA_BIT      1
`define MPR_CFG_LD_BIT      2
`define MPR_BASE_ONE_BIT    1

`define MPR_ID_REV_LSB      28
`define MPR_ID_BANK_LSB     24
`define MPR_ID_CODE_LSB     17
`define MPR_ID_PORT_BIT     16

`define MPR_RESP_OKAY       2'h0
`define MPR_RESP_SLVERR     2'h2

`endif

// file: core/mpr_read_mux.v
// Read data selection for the register bank
`include "mpr_defs.vh"

module mpr_read_mux (
    input  wire [7:0]  addr,        // Read byte address
    input  wire [2:0]  bar_ctrl,    // Barrier type and trigger
    input  wire [31:0] base_high,   // Upper base word
    input  wire [31:0] base_low,    // Lower base word, bit 1 set
    input  wire [2:0]  cfg_bits,    // Capability bits
    input  wire [31:0] ident,       // Identification word
    input  wire        long_addr,   // Long addressing built in
    output reg  [31:0] data,        // Selected word
    output reg         hit          // Address is mapped
);
    // Decode; reserved bits are zero, 0xF0 reserved without long addressing
    always @* begin
        data = 32'h00000000;
        hit  = 1'b1;
        case (addr)
            `MPR_OFF_BARRIER:   data = {29'h00000000, bar_ctrl};
            `MPR_OFF_CONFIG:    data = {29'h00000000, cfg_bits};
            `MPR_OFF_BASE_HIGH: begin
                if (long_addr) begin
                    data = base_high;
                end else begin
                    hit = 1'b0;
                end
            end
            `MPR_OFF_BASE_LOW:  data = base_low;
            `MPR_OFF_IDENT:     data = ident;
            default:            hit  = 1'b0;
        endcase
    end
endmodule // mpr_read_mux

// file: core/mpr_write_dec.v
// Write decode and barrier control register
`include "mpr_defs.vh"

module mpr_write_dec (
    input  wire        aclk,        // Clock
    input  wire        aresetn,     // Synchronous reset, active low
    input  wire        wr_fire,     // One write accepted this cycle
    input  wire [7:0]  addr,        // Write byte address
    input  wire [31:0] wdata,       // Write data
    input  wire        wstrb0,      // Byte lane 0 enable
    output reg  [2:0]  bar_ctrl,    // Barrier type and trigger
    output reg         hit          // Address is mapped
);
    reg [2:0] bar_ctrl_next;

    // Only the barrier control register is writable
    always @* begin
        bar_ctrl_next = bar_ctrl;
        hit = (addr == `MPR_OFF_BARRIER) || (addr == `MPR_OFF_CONFIG) ||
              (addr == `MPR_OFF_BASE_HIGH) || (addr == `MPR_OFF_BASE_LOW) ||
              (addr == `MPR_OFF_IDENT);
        if (wr_fire && wstrb0 && addr == `MPR_OFF_BARRIER) begin
            bar_ctrl_next = wdata[2:0];
        end
    end

    // Barrier control state with defined reset
    always @(posedge aclk) begin
        if (!aresetn) begin
            bar_ctrl <= {`MPR_BAR_TYPE_RST, `MPR_BAR_TRIG_RST};
        end else begin
            bar_ctrl <= bar_ctrl_next;
        end
    end
endmodule // mpr_write_dec

// file: core/mpr_top.v
// Register bank top: AXI4-Lite slave, base, capability and identity words
//
// Chosen here: the AXI4-Lite slave port.
`include "mpr_defs.vh"

module mpr_top #(
    parameter [3:0] REVISION   = 4'h1,   // Arbitrary value
    parameter [3:0] MAKER_BANK = 4'h0,   // Arbitrary value
    parameter [6:0] MAKER_CODE = 7'h11,  // Arbitrary value
    parameter [7:0] PORT_TYPE  = 8'h22,  // Arbitrary value
    parameter       LARGE_DATA = 1'b0,   // 64-bit data items supported
    parameter       LONG_ADDR  = 1'b1    // 64-bit addressing supported
) (
    input  wire        aclk,            // Clock, 250 MHz
    input  wire        aresetn,         // Synchronous reset, active low
    input  wire [31:0] base_tie_high,   // Static upper base tie-off
    input  wire [31:0] base_tie_low,    // Static lower base tie-off
    output wire [1:0]  barrier_type,    // Selected barrier kind
    output wire        barrier_trigger, // Barrier issue enable
    input  wire [31:0] s_awaddr,        // Write address
    input  wire [2:0]  s_awprot,        // Write protection, unused
    input  wire        s_awvalid,       // Write address valid
    output wire        s_awready,       // Write address ready
    input  wire [31:0] s_wdata,         // Write data
    input  wire [3:0]  s_wstrb,         // Write strobes
    input  wire        s_wvalid,        // Write data valid
    output wire        s_wready,        // Write data ready
    output reg  [1:0]  s_bresp,         // Write response
    output reg         s_bvalid,        // Write response valid
    input  wire        s_bready,        // Write response ready
    input  wire [31:0] s_araddr,        // Read address
    input  wire [2:0]  s_arprot,        // Read protection, unused
    input  wire        s_arvalid,       // Read address valid
    output wire        s_arready,       // Read address ready
    output reg  [31:0] s_rdata,         // Read data
    output reg  [1:0]  s_rresp,         // Read response
    output reg         s_rvalid,        // Read response valid
    input  wire        s_rready         // Read response ready
);
    reg         aw_held_reg;
    reg  [7:0]  aw_addr_reg;
    reg         w_held_reg;
    reg  [31:0] w_data_reg;
    reg         w_strb0_reg;
    wire [2:0]  bar_ctrl;
    wire        wr_hit;
    wire        rd_hit;
    wire [31:0] rd_data;
    wire        wr_fire;
    wire [31:0] base_low_word;
    wire [31:0] ident_word;
    wire [2:0]  cfg_bits;

    // Accept address and data in either order, one write at a time
    assign s_awready = !aw_held_reg && !s_bvalid;
    assign s_wready  = !w_held_reg && !s_bvalid;
    assign wr_fire   = aw_held_reg && w_held_reg;
    assign s_arready = !s_rvalid;

    // Fixed words assembled from ties and parameters
    assign base_low_word = base_tie_low | (32'h00000001 << `MPR_BASE_ONE_BIT);
    assign cfg_bits = {LARGE_DATA[0], LONG_ADDR[0], 1'b0};
    assign ident_word = {REVISION, MAKER_BANK, MAKER_CODE, 1'b1, 8'h00, PORT_TYPE};
    assign barrier_type    = bar_ctrl[`MPR_BAR_TYPE_MSB:`MPR_BAR_TYPE_LSB];
    assign barrier_trigger = bar_ctrl[`MPR_BAR_TRIG_BIT];

    mpr_write_dec u_wr (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .wr_fire  (wr_fire),
        .addr     (aw_addr_reg),
        .wdata    (w_data_reg),
        .wstrb0   (w_strb0_reg),
        .bar_ctrl (bar_ctrl),
        .hit      (wr_hit)
    );

    mpr_read_mux u_rd (
        .addr      ({s_araddr[7:2], 2'b00}),
        .bar_ctrl  (bar_ctrl),
        .base_high (base_tie_high),
        .base_low  (base_low_word),
        .cfg_bits  (cfg_bits),
        .ident     (ident_word),
        .long_addr (LONG_ADDR[0]),
        .data      (rd_data),
        .hit       (rd_hit)
    );

    // Write channel capture and response
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_held_reg  <= 1'b0;
            w_data_reg  <= 32'h00000000;
            w_strb0_reg <= 1'b0;
            s_bvalid    <= 1'b0;
            s_bresp     <= `MPR_RESP_OKAY;
        end else begin
            if (s_awvalid && s_awready) begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= {s_awaddr[7:2], 2'b00};
            end
            if (s_wvalid && s_wready) begin
                w_held_reg  <= 1'b1;
                w_data_reg  <= s_wdata;
                w_strb0_reg <= s_wstrb[0];
            end
            if (wr_fire) begin
                aw_held_reg <= 1'b0;
                w_held_reg  <= 1'b0;
                s_bvalid    <= 1'b1;
                s_bresp     <= wr_hit ? `MPR_RESP_OKAY : `MPR_RESP_SLVERR;
            end else if (s_bvalid && s_bready) begin
                s_bvalid <= 1'b0;
            end
        end
    end

    // Read channel: data registered, no side effects
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_rvalid <= 1'b0;
            s_rdata  <= 32'h00000000;
            s_rresp  <= `MPR_RESP_OKAY;
        end else if (s_arvalid && s_arready) begin
            s_rvalid <= 1'b1;
            s_rdata  <= rd_data;
            s_rresp  <= rd_hit ? `MPR_RESP_OKAY : `MPR_RESP_SLVERR;
        end else if (s_rvalid && s_rready) begin
            s_rvalid <= 1'b0;
        end
    end
endmodule // mpr_top

// file: tb/mpr_tie_model.sv
// Static base-address tie-off source standing in for the integrator
module mpr_tie_model #(
    parameter logic [31:0] HIGH_VAL = 32'h0000_00A5,   // Upper tie-off word
    parameter logic [31:0] LOW_VAL  = 32'h8000_1001    // Lower tie-off word, bit 1 low on purpose
) (
    output logic [31:0] tie_high,  // Upper base bus
    output logic [31:0] tie_low    // Lower base bus
);
    timeunit 1ns;
    timeprecision 1ps;
    // Bit 0 tied high: debug parts present on the far bus
    assign tie_high = HIGH_VAL;
    assign tie_low  = {LOW_VAL[31:1], 1'b1};
endmodule // mpr_tie_model

// file: tb/mpr_top_properties.sv
// Concurrent checks on the register bank top ports
module mpr_top_properties (
    input logic        aclk,            // Clock
    input logic        aresetn,         // Reset, active low
    input logic [31:0] base_tie_high,   // Upper tie-off
    input logic [31:0] base_tie_low,    // Lower tie-off
    input logic [1:0]  barrier_type,    // Barrier kind
    input logic        barrier_trigger, // Barrier enable
    input logic [31:0] s_araddr,        // Read address
    input logic        s_arvalid,       // Read address valid
    input logic        s_arready,       // Read address ready
    input logic [31:0] s_rdata,         // Read data
    input logic [1:0]  s_rresp,         // Read response
    input logic        s_rvalid,        // Read valid
    input logic        s_rready,        // Read ready
    input logic [1:0]  s_bresp,         // Write response
    input logic        s_bvalid,        // Write valid
    input logic        s_bready         // Write ready
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic ar_fire;
    assign ar_fire = s_arvalid && s_arready;
    // Read answer and holding of responses
    a_read_latency: assert property (ar_fire |=> s_rvalid) else $error("read not answered");
    a_rdata_hold: assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
        else $error("read data dropped");
    a_bresp_hold: assert property (s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
        else $error("write response dropped");
    // Read values of the fixed words and refusal of an unmapped read
    a_base_high: assert property (ar_fire && s_araddr[7:0] == 8'hF0 |=> s_rdata == base_tie_high)
        else $error("base high wrong");
    a_base_low: assert property (ar_fire && s_araddr[7:0] == 8'hF8
        |=> s_rdata == {base_tie_low[31:2], 1'b1, base_tie_low[0]}) else $error("base low wrong");
    a_cfg_endian: assert property (ar_fire && s_araddr[7:0] == 8'hF4
        |=> s_rdata[0] == 1'b0 && s_rdata[31:3] == 29'h0) else $error("config bits wrong");
    a_ident_flag: assert property (ar_fire && s_araddr[7:0] == 8'hFC
        |=> s_rdata[16] && s_rdata[15:8] == 8'h00) else $error("ident fields wrong");
    a_unmapped_err: assert property (ar_fire && s_araddr[7:0] == 8'hE0
        |=> s_rresp == 2'h2 && s_rdata == 32'h0) else $error("unmapped read not refused");
    // Barrier outputs come out of reset clear and move only with a write response
    a_barrier_reset: assert property ($rose(aresetn) |-> barrier_type == 2'h0 && !barrier_trigger)
        else $error("barrier not reset");
    a_barrier_change: assert property ($changed({barrier_type, barrier_trigger}) && $past(aresetn)
        |-> $rose(s_bvalid)) else $error("barrier changed without write");
endmodule // mpr_top_properties
bind mpr_top mpr_top_properties mpr_top_properties_i (.aclk, .aresetn, .base_tie_high,
    .base_tie_low, .barrier_type, .barrier_trigger, .s_araddr, .s_arvalid, .s_arready, .s_rdata,
    .s_rresp, .s_rvalid, .s_rready, .s_bresp, .s_bvalid, .s_bready);

// file: tb/mpr_read_mux_tb_top.sv
// Self-checking bench for the register bank over AXI4-Lite
module mem_port_info_barrier_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 0, aresetn = 0, s_awvalid = 0, s_wvalid = 0, s_bready = 0, s_arvalid = 0;
    logic s_rready = 0, s_awready, s_wready, s_bvalid, s_arready, s_rvalid, b_trig;
    logic [31:0] s_awaddr = 0, s_wdata = 0, s_araddr = 0, s_rdata, t_hi, t_lo, rd;
    logic [3:0]  s_wstrb = 0;
    logic [1:0]  s_bresp, s_rresp, b_type, rs;
    logic [2:0]  s_awprot = 3'h0, s_arprot = 3'h0;
    int num_errors = 0, samples_checked = 0;
    // Edges the master waits before raising bready or rready, so held answers get exercised
    int ready_lag = 0;
    localparam logic [31:0] ID_EXP = {4'h5, 4'h6, 7'h2A, 1'b1, 8'h00, 8'h5C};
    always #2 aclk = ~aclk;
    mpr_tie_model mpr_tie_model_i (.tie_high(t_hi), .tie_low(t_lo));
    // Identity values are arbitrary
    mpr_top #(.REVISION(4'h5), .MAKER_BANK(4'h6), .MAKER_CODE(7'h2A), .PORT_TYPE(8'h5C),
        .LARGE_DATA(1'b1)) mpr_top_i (.aclk(aclk), .aresetn(aresetn),
        .base_tie_high(t_hi), .base_tie_low(t_lo), .barrier_type(b_type), .barrier_trigger(b_trig),
        .s_awaddr(s_awaddr), .s_awprot(s_awprot), .s_awvalid(s_awvalid), .s_awready(s_awready),
        .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
        .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr),
        .s_arprot(s_arprot), .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata),
        .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready));
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One write; settled values sampled mid-cycle, released after the taking edge
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] st, output logic [1:0] r);
        logic ah, wh, bh;
        int n;
        n = 0;
        s_awaddr <= {24'h0, a}; s_wdata <= d; s_wstrb <= st; s_awprot <= 3'h2;
        s_awvalid <= 1; s_wvalid <= 1; s_bready <= (ready_lag == 0);
        forever begin
            @(negedge aclk);
            ah = s_awvalid && s_awready; wh = s_wvalid && s_wready;
            bh = s_bvalid && s_bready; r = s_bresp;
            @(posedge aclk);
            n++;
            if (ah) s_awvalid <= 0;
            if (wh) s_wvalid <= 0;
            if (bh) break;
            if (n >= ready_lag) s_bready <= 1;
        end
        s_bready <= 0;
        @(posedge aclk);
    endtask
    // One read; data taken in the cycle whose closing edge sees rvalid and rready high
    task rdw(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ah, rh;
        int n;
        n = 0;
        s_araddr <= {24'h0, a}; s_arprot <= 3'h2; s_arvalid <= 1; s_rready <= (ready_lag == 0);
        forever begin
            @(negedge aclk);
            ah = s_arvalid && s_arready; rh = s_rvalid && s_rready; d = s_rdata; r = s_rresp;
            @(posedge aclk);
            n++;
            if (ah) s_arvalid <= 0;
            if (rh) break;
            if (n >= ready_lag) s_rready <= 1;
        end
        s_rready <= 0;
        @(posedge aclk);
    endtask
    task do_reset();
        aresetn <= 0;
        repeat (4) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        chk({b_type, b_trig}, 32'h0);
    endtask
    task end_of_test();
        $display("checks=%0d mismatches=%0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        #20000;
        num_errors++;
        end_of_test();
    end
    // Main sequence
    initial begin
        @(posedge aclk);
        do_reset();
        rdw(8'hE8, rd, rs); chk(rd, 32'h0);
        for (int k = 0; k < 8; k++) begin
            wr(8'hE8, {29'h1FFFFFFF, k[2:0]}, 4'hF, rs); chk(rs, 32'h0);
            chk({b_type, b_trig}, k);
            rdw(8'hE8, rd, rs); chk(rd, k);
        end
        wr(8'hE8, 32'h0, 4'h0, rs); chk({b_type, b_trig}, 32'h7);
        $display("barrier test done");
        // Late readies from here on: the answers must stand until taken
        ready_lag = 3;
        wr(8'hF0, 32'h1234, 4'hF, rs); chk(rs, 32'h0);
        rdw(8'hF0, rd, rs); chk(rd, t_hi);
        rdw(8'hF8, rd, rs); chk(rd, {t_lo[31:2], 1'b1, t_lo[0]});
        rdw(8'hF4, rd, rs); chk(rd, 32'h6);
        rdw(8'hFC, rd, rs); chk(rd, ID_EXP);
        rdw(8'hE0, rd, rs); chk(rd, 32'h0);
        chk(rs, 32'h2);
        wr(8'hE0, 32'h5, 4'hF, rs); chk(rs, 32'h2);
        $display("info test done");
        do_reset();
        $display("reset test done");
        end_of_test();
    end
endmodule // mem_port_info_barrier_regs_tb_top
